/* File: edge_gap_timer.v */
`timescale 1ns/10ps
// minimum edge gap: ready once 2^n clocks have passed since last edge
module edge_gap_timer (
  // clock and reset
  input wire CLK,
  input wire RST_N,
  // control
  input wire [2:0] gap_n,
  input wire edge_seen,
  // status
  output wire gap_ok
);
  reg [7:0] cnt_ff;
  wire [7:0] limit;
  assign limit = 8'h01 << gap_n;
  // count clocks since the last output edge, saturate at the limit
  always @(posedge CLK) begin
    if (!RST_N) begin
      cnt_ff <= 8'hff;
    end else if (edge_seen) begin
      cnt_ff <= 8'h01;
    end else if (cnt_ff < limit) begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end
  assign gap_ok = (cnt_ff >= limit);
endmodule // edge_gap_timer

/* File: fault_flag_cell.v */
`timescale 1ns/10ps
// one fault flag: saved or live, saved flag held until the clear command
module fault_flag_cell (
  // clock and reset
  input wire CLK,
  input wire RST_N,
  // controls
  input wire det_en,
  input wire latch_en,
  input wire clear,
  input wire raw,
  // flag
  output reg flag_ff
);
  wire hit;
  assign hit = raw & det_en;
  // set wins over clear
  always @(posedge CLK) begin
    if (!RST_N) begin
      flag_ff <= 1'b0;
    end else if (!latch_en) begin
      flag_ff <= hit;
    end else if (hit) begin
      flag_ff <= 1'b1;
    end else if (clear) begin
      flag_ff <= 1'b0;
    end
  end
endmodule // fault_flag_cell

/* File: ifc_consts.vh */
`ifndef IFC_CONSTS_VH
`define IFC_CONSTS_VH
// register addresses (byte address of the first byte of each word)
`define ADDR_STATUS 8'h08
`define ADDR_FAULT_AND_OUTPUT_CONFIG 8'h0c
`define ADDR_FILTER_TRIGGER_PHASE_CONFIG 8'h10
`define ADDR_TIMER_AND_INDEX_CONFIG 8'h14
// reset values
`define FAULT_AND_OUTPUT_CONFIG_RST 32'h00ff0900
`define FILTER_TRIGGER_PHASE_CONFIG_RST 32'h0000000a
`define TIMER_AND_INDEX_CONFIG_RST 32'h00008000
// configuration word 1 field positions
`define C1_TRI 31
`define C1_LATCH_HI 30
`define C1_LATCH_LO 24
`define C1_FREEZE 23
`define C1_DET_HI 22
`define C1_DET_LO 16
`define C1_DET_QUAD 19
`define C1_HYS_HI 13
`define C1_HYS_LO 11
`define C1_GAP_HI 10
`define C1_GAP_LO 8
`define C1_IR_HI 4
`define C1_IR_LO 0
// configuration word 2 / 3 positions
`define C2_TRGSEL 23
`define C3_VT_HI 25
`define C3_VT_LO 24
`define C3_T_HI 23
`define C3_T_LO 16
`define C3_COEF 15
`define C3_PHFIX 14
// fault group indices (latch and detect bit order, lsb first)
`define G_VEC 3'h0
`define G_ADC 3'h1
`define G_FAST 3'h2
`define G_QUAD 3'h3
`define G_GAIN 3'h4
`define G_OFF 3'h5
`define G_KOVL 3'h6
// arbitrary neutral identity values
`define ID_CODE 4'h0
`define REV_CODE 4'h0
`endif

/* File: ifc_properties.sv */
`timescale 1ns/10ps
// port checks for the register bank
module ifc_properties (
  // clock, reset, register port
  input wire CLK,
  input wire RST_N,
  input wire [7:0] REG_ADDR,
  input wire REG_WR,
  input wire [31:0] REG_WDATA,
  // trigger, pins, faults
  input wire TRIGGER_IN,
  input wire TRIGGER_EVENT,
  input wire PIN_A,
  input wire PIN_B,
  input wire PIN_Z,
  input wire PIN_OE_N,
  input wire ANY_FAULT,
  // configuration outputs
  input wire SQUARE_WAVE_MODE,
  input wire HYSTERESIS_ON,
  input wire [2:0] HYSTERESIS_THRESHOLD,
  input wire [4:0] INTERP_RATE_CODE,
  input wire COEF_SCALE_18,
  input wire PHASE_FIX_ACTIVE,
  input wire [6:0] PHASE_SETTING
);
  reg frz_ff, tri_ff, sel_ff;
  reg [31:0] wd_ff;
  default clocking dc @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // shadow of output and trigger controls
  always @(posedge CLK) begin
    wd_ff <= REG_WDATA;
    if (!RST_N) begin
      frz_ff <= 1'b1;
      tri_ff <= 1'b0;
      sel_ff <= 1'b0;
    end else if (REG_WR && REG_ADDR == 8'h0c) begin
      frz_ff <= REG_WDATA[23];
      tri_ff <= REG_WDATA[31];
    end else if (REG_WR && REG_ADDR == 8'h10) begin
      sel_ff <= REG_WDATA[23];
    end
  end
  sequence hold_s; (frz_ff && !tri_ff && ANY_FAULT) [*2]; endsequence
  sequence float_s; (tri_ff && ANY_FAULT) [*2]; endsequence
  sequence trg_s; sel_ff ? $rose(TRIGGER_IN) : $fell(TRIGGER_IN); endsequence
  a_cfg_follows: assert property (
    REG_WR && REG_ADDR == 8'h0c |=> SQUARE_WAVE_MODE == wd_ff[19] &&
    INTERP_RATE_CODE == wd_ff[4:0]) else $error("fault_and_output_config not applied");
  a_coef_follows: assert property (
    REG_WR && REG_ADDR == 8'h14 |=> COEF_SCALE_18 == wd_ff[15] &&
    PHASE_FIX_ACTIVE == wd_ff[14]) else $error("timer_and_index_config not applied");
  a_hys_zero_off: assert property (
    HYSTERESIS_ON == (HYSTERESIS_THRESHOLD != 3'h0))
    else $error("hysteresis enable wrong");
  a_phase_ignored: assert property (
    !PHASE_FIX_ACTIVE |-> PHASE_SETTING == 7'h0)
    else $error("phase setting leaks");
  a_reset_values: assert property (
    !$past(RST_N) |-> SQUARE_WAVE_MODE && HYSTERESIS_THRESHOLD == 3'h1 &&
    INTERP_RATE_CODE == 5'h0 && COEF_SCALE_18 && !PHASE_FIX_ACTIVE)
    else $error("reset values wrong");
  a_oe_cause: assert property (
    $rose(PIN_OE_N) |-> ANY_FAULT || $past(ANY_FAULT))
    else $error("pins float without fault");
  a_fault_floats: assert property (
    float_s |-> PIN_OE_N) else $error("pins driven in fault");
  a_freeze_holds: assert property (
    hold_s |-> $stable(PIN_A) && $stable(PIN_B) && $stable(PIN_Z))
    else $error("pins moved in fault");
  a_trig_edge: assert property (
    trg_s |-> ##[1:3] TRIGGER_EVENT) else $error("trigger missed");
  a_trig_pulse: assert property (
    TRIGGER_EVENT |=> !TRIGGER_EVENT) else $error("trigger too long");
endmodule // ifc_properties
bind interpolator_fault_config_regs ifc_properties ifc_properties_inst (.*);

/* File: interpolator_fault_config_regs.v */
`timescale 1ns/10ps
`include "ifc_consts.vh"
// Overview of operation
// RQ1: tri-state bit set floats A, B, index outputs on any error.
// RQ2: freeze bit set holds A, B, index output states during errors.
// RQ3: seven latch bits, one per fault group, save detected flags.
// RQ4: seven detect enables, reset one, suppress a group's faults when clear.
// RQ5: quadrature detect enable also picks square-wave or counter mode.
// RQ6: hysteresis threshold field resets to one; zero disables hysteresis.
// RQ7: edge gap field N gives minimum edge spacing of 2^N clocks.
// RQ8: five-bit interpolation rate code at the bottom, reset zero.
// RQ9: trigger edge bit picks falling at zero, rising at one.
// RQ10: timer period T+1 ticks; zero clock select and T disables.
// RQ11: coefficient scale bit picks 16-bit at zero, 18-bit at one.
// RQ12: phase fix enable clear makes phase fields ignored.
// RQ13: sine and cosine converter fault flags, reset zero.
// RQ14: saved flags stay until the count clear command.
// RQ15: unsaved flags follow the live detected condition each cycle.
module interpolator_fault_config_regs (
  // clock and reset
  input wire CLK,
  input wire RST_N,
  // register port
  input wire [7:0] REG_ADDR,
  input wire REG_WR,
  input wire [31:0] REG_WDATA,
  input wire REG_RD,
  output reg [31:0] REG_RDATA,
  // clear command
  input wire CLEAR_COUNT_ERRORS_CMD,
  // raw fault inputs
  input wire RAW_CORRECTION_OVERFLOW,
  input wire RAW_SINE_OFFSET,
  input wire RAW_COSINE_OFFSET,
  input wire RAW_SINE_GAIN,
  input wire RAW_COSINE_GAIN,
  input wire RAW_QUADRATURE,
  input wire RAW_OVERSPEED,
  input wire RAW_SINE_CONVERTER,
  input wire RAW_COSINE_CONVERTER,
  input wire RAW_VECTOR,
  // quadrature outputs from the interpolator core
  input wire CORE_A,
  input wire CORE_B,
  input wire CORE_Z,
  // trigger pin
  input wire TRIGGER_IN,
  // timer clock tick of the selected source
  input wire TIMER_TICK,
  // pins A, B, Z (enable low drives)
  output reg PIN_A,
  output reg PIN_B,
  output reg PIN_Z,
  output reg PIN_OE_N,
  // configuration out to the core
  output wire SQUARE_WAVE_MODE,
  output wire HYSTERESIS_ON,
  output wire [2:0] HYSTERESIS_THRESHOLD,
  output wire [4:0] INTERP_RATE_CODE,
  output wire COEF_SCALE_18,
  output wire PHASE_FIX_ACTIVE,
  output wire [6:0] PHASE_SETTING,
  output reg TRIGGER_EVENT,
  output reg TIMER_EVENT,
  output wire ANY_FAULT
);
  reg [31:0] fault_and_output_config_ff;
  reg [31:0] filter_trigger_phase_config_ff;
  reg [31:0] timer_and_index_config_ff;
  reg trig_d_ff;
  reg [7:0] tmr_ff;
  wire [6:0] latch_en;
  wire [6:0] det_en;
  wire [9:0] raw;
  wire [9:0] flag;
  wire [9:0] det_bit;
  wire [9:0] lat_bit;
  wire sel_status;
  wire sel_fault_and_output_config;
  wire sel_filter_trigger_phase_config;
  wire sel_timer_and_index_config;
  wire pass_ok;
  reg [31:0] rd_word;
  wire clear;
  wire gap_ok;
  wire out_edge;
  wire [15:0] status_lo;
  wire timer_off;

  // address match helper
  function hit;
    input [7:0] a;
    input [7:0] b;
    begin
      hit = (a == b);
    end
  endfunction

  // register selects, shared by the write and read paths
  assign sel_status = hit(REG_ADDR, `ADDR_STATUS);
  assign sel_fault_and_output_config = hit(REG_ADDR, `ADDR_FAULT_AND_OUTPUT_CONFIG);
  assign sel_filter_trigger_phase_config = hit(REG_ADDR, `ADDR_FILTER_TRIGGER_PHASE_CONFIG);
  assign sel_timer_and_index_config = hit(REG_ADDR, `ADDR_TIMER_AND_INDEX_CONFIG);

  // configuration writes, status writes are dropped
  always @(posedge CLK) begin
    if (!RST_N) begin
      fault_and_output_config_ff <= `FAULT_AND_OUTPUT_CONFIG_RST;
      filter_trigger_phase_config_ff <= `FILTER_TRIGGER_PHASE_CONFIG_RST;
      timer_and_index_config_ff <= `TIMER_AND_INDEX_CONFIG_RST;
    end else if (REG_WR) begin
      if (sel_fault_and_output_config) begin
        fault_and_output_config_ff <= REG_WDATA;
      end
      if (sel_filter_trigger_phase_config) begin
        filter_trigger_phase_config_ff <= REG_WDATA;
      end
      if (sel_timer_and_index_config) begin
        timer_and_index_config_ff <= REG_WDATA;
      end
    end
  end

  assign latch_en = fault_and_output_config_ff[`C1_LATCH_HI:`C1_LATCH_LO]; // [RQ3]
  assign det_en = fault_and_output_config_ff[`C1_DET_HI:`C1_DET_LO]; // [RQ4]
  assign clear = CLEAR_COUNT_ERRORS_CMD; // [RQ14]

  // raw sources, index order matches the status bits below
  assign raw[9] = RAW_CORRECTION_OVERFLOW;
  assign raw[8] = RAW_SINE_OFFSET;
  assign raw[7] = RAW_COSINE_OFFSET;
  assign raw[6] = RAW_SINE_GAIN;
  assign raw[5] = RAW_COSINE_GAIN;
  assign raw[4] = RAW_QUADRATURE;
  assign raw[3] = RAW_OVERSPEED;
  assign raw[2] = RAW_SINE_CONVERTER;
  assign raw[1] = RAW_COSINE_CONVERTER;
  assign raw[0] = RAW_VECTOR;

  // group of each flag
  function [2:0] grp;
    input integer i;
    begin
      case (i)
        9: grp = `G_KOVL;
        8: grp = `G_OFF;
        7: grp = `G_OFF;
        6: grp = `G_GAIN;
        5: grp = `G_GAIN;
        4: grp = `G_QUAD;
        3: grp = `G_FAST;
        2: grp = `G_ADC;
        1: grp = `G_ADC;
        default: grp = `G_VEC;
      endcase
    end
  endfunction

  // one flag cell per fault source
  genvar gi;
  generate
    for (gi = 0; gi < 10; gi = gi + 1) begin : g_flag
      // group enables of this flag only
      assign det_bit[gi] = det_en[grp(gi)];
      assign lat_bit[gi] = latch_en[grp(gi)];
      fault_flag_cell u_cell (
        .CLK(CLK),
        .RST_N(RST_N),
        .det_en(det_bit[gi]), // [RQ4]
        .latch_en(lat_bit[gi]), // [RQ3] [RQ15]
        .clear(clear), // [RQ14]
        .raw(raw[gi]),
        .flag_ff(flag[gi])
      );
    end
  endgenerate

  // low status half: bit 15 and 8..0, bits 14..9 read as zero
  assign status_lo[15] = flag[9]; // correction overflow
  assign status_lo[14:9] = 6'h00;
  assign status_lo[8] = flag[8]; // sine offset
  assign status_lo[7] = flag[7]; // cosine offset
  assign status_lo[6] = flag[6]; // sine gain
  assign status_lo[5] = flag[5]; // cosine gain
  assign status_lo[4] = flag[4]; // quadrature output
  assign status_lo[3] = flag[3]; // overspeed
  assign status_lo[2] = flag[2]; // sine converter [RQ13]
  assign status_lo[1] = flag[1]; // cosine converter [RQ13]
  assign status_lo[0] = flag[0]; // vector too small
  assign ANY_FAULT = |flag;

  // read mux, unmapped addresses give zero
  always @* begin
    rd_word = 32'h00000000;
    if (sel_status) begin
      rd_word = {`ID_CODE, `REV_CODE, 8'h00, status_lo};
    end
    if (sel_fault_and_output_config) begin
      rd_word = fault_and_output_config_ff;
    end
    if (sel_filter_trigger_phase_config) begin
      rd_word = filter_trigger_phase_config_ff;
    end
    if (sel_timer_and_index_config) begin
      rd_word = timer_and_index_config_ff;
    end
  end

  // read data held until the next read strobe
  always @(posedge CLK) begin
    if (!RST_N) begin
      REG_RDATA <= 32'h00000000;
    end else if (REG_RD) begin
      REG_RDATA <= rd_word;
    end
  end

  // configuration decode
  // mode and hysteresis
  assign SQUARE_WAVE_MODE = fault_and_output_config_ff[`C1_DET_QUAD]; // [RQ5]
  assign HYSTERESIS_THRESHOLD = fault_and_output_config_ff[`C1_HYS_HI:`C1_HYS_LO];
  assign HYSTERESIS_ON = |HYSTERESIS_THRESHOLD; // [RQ6]
  assign INTERP_RATE_CODE = fault_and_output_config_ff[`C1_IR_HI:`C1_IR_LO]; // [RQ8]
  // coefficient scale and phase correction
  assign COEF_SCALE_18 = timer_and_index_config_ff[`C3_COEF]; // [RQ11]
  assign PHASE_FIX_ACTIVE = timer_and_index_config_ff[`C3_PHFIX];
  // phase setting forced to zero while correction is off
  assign PHASE_SETTING = PHASE_FIX_ACTIVE ? filter_trigger_phase_config_ff[22:16] : 7'h00; // [RQ12]

  // pins pass core levels unless a fault floats or freezes them
  assign pass_ok = ~(ANY_FAULT & (fault_and_output_config_ff[`C1_TRI] | fault_and_output_config_ff[`C1_FREEZE]));

  // minimum edge separation on the quadrature outputs
  // restart only on an edge that really reaches the pins
  assign out_edge = (PIN_A != CORE_A) | (PIN_B != CORE_B);
  edge_gap_timer u_gap (
    .CLK(CLK),
    .RST_N(RST_N),
    .gap_n(fault_and_output_config_ff[`C1_GAP_HI:`C1_GAP_LO]), // [RQ7]
    .edge_seen(out_edge & gap_ok & pass_ok), // [RQ1] [RQ2]
    .gap_ok(gap_ok)
  );

  // output pins: float, freeze or pass on fault
  // float wins over freeze when both bits are set
  always @(posedge CLK) begin
    if (!RST_N) begin
      PIN_A <= 1'b0;
      PIN_B <= 1'b0;
      PIN_Z <= 1'b0;
      PIN_OE_N <= 1'b0;
    end else if (ANY_FAULT && fault_and_output_config_ff[`C1_TRI]) begin
      PIN_OE_N <= 1'b1; // [RQ1]
    end else if (ANY_FAULT && fault_and_output_config_ff[`C1_FREEZE]) begin
      PIN_OE_N <= 1'b0; // [RQ2] states held
    end else begin
      PIN_OE_N <= 1'b0;
      PIN_Z <= CORE_Z;
      if (gap_ok) begin
        PIN_A <= CORE_A; // [RQ7]
        PIN_B <= CORE_B;
      end
    end
  end

  // trigger edge detect with polarity select
  // last level kept every cycle, so a polarity change fakes no edge
  always @(posedge CLK) begin
    if (!RST_N) begin
      trig_d_ff <= 1'b0;
      TRIGGER_EVENT <= 1'b0;
    end else begin
      trig_d_ff <= TRIGGER_IN;
      if (filter_trigger_phase_config_ff[`C2_TRGSEL]) begin
        TRIGGER_EVENT <= TRIGGER_IN & ~trig_d_ff; // [RQ9]
      end else begin
        TRIGGER_EVENT <= ~TRIGGER_IN & trig_d_ff; // [RQ9]
      end
    end
  end

  // timer: event every T+1 ticks, off when select and T are zero
  // a smaller new T is caught by the compare, no wrap through 255
  assign timer_off = (timer_and_index_config_ff[`C3_VT_HI:`C3_VT_LO] == 2'b00) &&
                     (timer_and_index_config_ff[`C3_T_HI:`C3_T_LO] == 8'h00); // [RQ10]
  always @(posedge CLK) begin
    if (!RST_N) begin
      tmr_ff <= 8'h00;
      TIMER_EVENT <= 1'b0;
    end else if (timer_off) begin
      tmr_ff <= 8'h00;
      TIMER_EVENT <= 1'b0;
    end else if (TIMER_TICK) begin
      if (tmr_ff >= timer_and_index_config_ff[`C3_T_HI:`C3_T_LO]) begin
        tmr_ff <= 8'h00;
        TIMER_EVENT <= 1'b1; // [RQ10]
      end else begin
        tmr_ff <= tmr_ff + 8'h01;
        TIMER_EVENT <= 1'b0;
      end
    end else begin
      TIMER_EVENT <= 1'b0;
    end
  end
endmodule // interpolator_fault_config_regs

/* File: test_interpolator_fault_config_regs.sv */
`timescale 1ns/10ps
// bench for the fault and configuration registers
module test_interpolator_fault_config_regs;
  reg clk = 0, rst_n = 0, wr = 0, rd = 0, clr = 0, tin = 0, tick = 0;
  reg ca = 0, cb = 0, cz = 0;
  reg [7:0] addr = 0;
  reg [31:0] wdat = 0;
  reg [9:0] raw = 0;
  wire [31:0] rdat;
  wire pa, pb, pz, oe_n, sqw, hon, c18, pfa, tev, mev, anyf;
  wire [2:0] hth;
  wire [4:0] irc;
  wire [6:0] phs;
  integer errors = 0, checks_done = 0, seed = 32'h2ef2d18f;
  integer c1, c2, c3, flg, det, lat, i, j, n;
  integer mq[$];
  int grp [10] = '{0, 1, 1, 2, 3, 4, 4, 5, 5, 6};
  interpolator_fault_config_regs interpolator_fault_config_regs_inst (
    .CLK(clk), .RST_N(rst_n), .REG_ADDR(addr), .REG_WR(wr),
    .REG_WDATA(wdat), .REG_RD(rd), .REG_RDATA(rdat),
    .CLEAR_COUNT_ERRORS_CMD(clr), .RAW_CORRECTION_OVERFLOW(raw[9]),
    .RAW_SINE_OFFSET(raw[8]), .RAW_COSINE_OFFSET(raw[7]),
    .RAW_SINE_GAIN(raw[6]), .RAW_COSINE_GAIN(raw[5]),
    .RAW_QUADRATURE(raw[4]), .RAW_OVERSPEED(raw[3]),
    .RAW_SINE_CONVERTER(raw[2]), .RAW_COSINE_CONVERTER(raw[1]),
    .RAW_VECTOR(raw[0]), .CORE_A(ca), .CORE_B(cb), .CORE_Z(cz),
    .TRIGGER_IN(tin), .TIMER_TICK(tick), .PIN_A(pa), .PIN_B(pb),
    .PIN_Z(pz), .PIN_OE_N(oe_n), .SQUARE_WAVE_MODE(sqw),
    .HYSTERESIS_ON(hon), .HYSTERESIS_THRESHOLD(hth),
    .INTERP_RATE_CODE(irc), .COEF_SCALE_18(c18),
    .PHASE_FIX_ACTIVE(pfa), .PHASE_SETTING(phs),
    .TRIGGER_EVENT(tev), .TIMER_EVENT(mev), .ANY_FAULT(anyf));
  // 100 mhz clock
  always #5 clk = ~clk;
  // compare and count
  task chk(input string nm, input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // register write, strobe held over one rising edge
  task wr_reg(input [7:0] a, input [31:0] d);
    @(negedge clk);
    addr = a;
    wdat = d;
    wr = 1;
    @(negedge clk);
    wr = 0;
  endtask
  // register read against the model
  task rd_reg(input [7:0] a, input [31:0] e);
    @(negedge clk);
    addr = a;
    rd = 1;
    @(negedge clk);
    rd = 0;
    chk("rdata", rdat, e);
  endtask
  // status word seen from the model flags
  function [31:0] st(input integer f);
    st = {f[9], 6'h0, f[8:0]};
  endfunction
  task final_report;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // watchdog
  initial begin
    #100000;
    errors++;
    final_report;
  end
  // main sequence
  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1;
    rd_reg(8'h08, 0);
    rd_reg(8'h0c, 32'h00ff0900);
    rd_reg(8'h10, 32'h0000000a);
    rd_reg(8'h14, 32'h00008000);
    rd_reg(8'h40, 0);
    for (i = 0; i < 8; i++) begin
      c1 = i ? $random(seed) : 0;
      c2 = $random(seed);
      c3 = $random(seed);
      wr_reg(8'h0c, c1);
      wr_reg(8'h10, c2);
      wr_reg(8'h14, c3);
      wr_reg(8'h08, c1);
      wr_reg(8'h44, c2);
      mq.push_back(c1);
      mq.push_back(c2);
      mq.push_back(c3);
      rd_reg(8'h0c, mq.pop_front());
      rd_reg(8'h10, mq.pop_front());
      rd_reg(8'h14, mq.pop_front());
      rd_reg(8'h08, 0);
      chk("mode", sqw, c1[19]);
      chk("hyst", {hon, hth}, {|c1[13:11], c1[13:11]});
      chk("rate", irc, c1[4:0]);
      chk("coef", c18, c3[15]);
      chk("phase", {pfa, phs}, {c3[14], c3[14] ? c2[22:16] : 7'h0});
    end
    // live and saved fault flags, then clear
    for (i = 0; i < 8; i++) begin
      c1 = ($random(seed) & 32'h7f7f0000) | 32'h00800900;
      wr_reg(8'h0c, c1);
      for (j = 0; j < 10; j++) begin
        det[j] = c1[16 + grp[j]];
        lat[j] = c1[24 + grp[j]];
      end
      raw = $random(seed);
      flg = raw & det;
      repeat (2) @(negedge clk);
      rd_reg(8'h08, st(flg));
      chk("any", anyf, flg != 0);
      raw = 0;
      flg = flg & lat;
      repeat (2) @(negedge clk);
      rd_reg(8'h08, st(flg));
      clr = 1;
      @(negedge clk);
      clr = 0;
      rd_reg(8'h08, 0);
    end
    // edge gap of 8 clocks on a fast toggling core
    wr_reg(8'h0c, 32'h00ff0b00);
    n = 0;
    for (i = 0; i < 40; i++) begin
      j = pa;
      @(negedge clk);
      ca = ~ca;
      n += (pa != j);
    end
    chk("gap", n >= 3 && n <= 6, 1);
    cz = 1;
    repeat (12) @(negedge clk);
    chk("pass", {pa, pb, pz, oe_n}, {ca, cb, cz, 1'b0});
    // freeze on fault, then release
    raw = 10'h001;
    repeat (3) @(negedge clk);
    j = {pa, pb, pz};
    ca = ~ca;
    cb = ~cb;
    cz = ~cz;
    repeat (12) @(negedge clk);
    chk("freeze", {pa, pb, pz, oe_n}, {j[2:0], 1'b0});
    raw = 0;
    repeat (12) @(negedge clk);
    chk("release", {pa, pb, pz}, {ca, cb, cz});
    // float on fault
    wr_reg(8'h0c, 32'h80ff0b00);
    raw = 10'h008;
    repeat (3) @(negedge clk);
    chk("float", oe_n, 1);
    raw = 0;
    repeat (3) @(negedge clk);
    chk("drive", oe_n, 0);
    // trigger edges for both polarities
    for (i = 0; i < 2; i++) begin
      wr_reg(8'h10, 32'h0a | (i << 23));
      for (j = 0; j < 2; j++) begin
        tin = ~tin;
        n = 0;
        repeat (4) @(negedge clk) n += tev;
        chk("trigger", n, tin == i);
      end
    end
    // timer off, then period of three ticks
    for (i = 0; i < 2; i++) begin
      wr_reg(8'h14, i ? 32'h01028000 : 32'h00008000);
      n = 0;
      repeat (9) begin
        @(negedge clk);
        tick = 1;
        n += mev;
        @(negedge clk);
        tick = 0;
        n += mev;
      end
      @(negedge clk);
      n += mev;
      chk("timer", n, i ? 3 : 0);
    end
    final_report;
  end
endmodule // test_interpolator_fault_config_regs
